// file: verification/acr_i2c_host.sv
// Pin model of the serial bus host that drives clock and data lines.
`timescale 1ns/1ps
`default_nettype none
module acr_i2c_host
(
	// Control from the bench.
	input  wire logic hold_i,
	input  wire logic run_i,
	// Serial pins, pulled up when released.
	output var  logic scl_o,
	output var  logic sda_o
);
	initial scl_o = 1'b1;
	// The clock stands high between frames, where the pull-up leaves it.
	always
	begin
		#40;
		scl_o = run_i ? ~scl_o : 1'b1;
	end
	always_comb sda_o = (hold_i || run_i) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// file: verification/acr_reg_bank_assertions.sv
// Port-level assertions for the accelerometer register bank.
`timescale 1ns/1ps
`default_nettype none
module acr_reg_bank_assertions
	import acr_pkg::*;
(
	// Clock, reset and register port.
	input wire logic       sys_clk_i,
	input wire logic       nrst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// Events and faults.
	input wire logic       fifo_full_i,
	input wire logic       fifo_watermark_i,
	input wire logic       data_ready_i,
	input wire logic       slow_fault_i,
	input wire logic       fatal_fault_i,
	// Outputs.
	input wire logic       irq_pin_a_o,
	input wire logic       irq_pin_b_o,
	input wire acr_cfg_t   cfg_o,
	input wire logic       nvm_store_o,
	input wire logic       wdt_timeout_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	logic any_ev;
	assign any_ev = fifo_full_i | fifo_watermark_i | data_ready_i;
	property p_pin_a;
		irq_pin_a_o |-> $past(any_ev);
	endproperty
	a_pin_a: assert property (p_pin_a) else $error("pin A without event");
	property p_pin_b;
		irq_pin_b_o |-> $past(any_ev);
	endproperty
	a_pin_b: assert property (p_pin_b) else $error("pin B without event");
	property p_rd_idle;
		!reg_rd_i |=> reg_rdata_o == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	property p_fault_resv;
		reg_rd_i && reg_addr_i == ADDR_INTERNAL_FAULT_FLAGS
			|=> (reg_rdata_o & 8'hf9) == 8'h00;
	endproperty
	a_fault_resv: assert property (p_fault_resv) else $error("fault bits");
	property p_store_cause;
		nvm_store_o |-> cfg_o.nvm_write_allow && $past(reg_wr_i
			&& reg_addr_i == ADDR_COMMAND && reg_wdata_i == CMD_NVM_STORE);
	endproperty
	a_store_cause: assert property (p_store_cause) else $error("bad store");
	property p_wdt_pulse;
		wdt_timeout_o |=> !wdt_timeout_o [*8];
	endproperty
	a_wdt_pulse: assert property (p_wdt_pulse) else $error("wdt pulse");
	property p_spi_excl;
		nrst_i && $past(nrst_i, 3) |-> cfg_o.i2c_enable == !cfg_o.spi_select;
	endproperty
	a_spi_excl: assert property (p_spi_excl) else $error("spi and i2c");
	property p_three_wire;
		reg_wr_i && reg_addr_i == ADDR_SERIAL_PORT_CONFIG
			|-> ##2 cfg_o.three_wire == $past(reg_wdata_i[THREE_WIRE], 2);
	endproperty
	a_three_wire: assert property (p_three_wire) else $error("3-wire");
	property p_halt_cause;
		$rose(cfg_o.processing_halt) |-> $past(slow_fault_i || fatal_fault_i, 2);
	endproperty
	a_halt_cause: assert property (p_halt_cause) else $error("halt");
	c_store: cover property (nvm_store_o);
	c_wdt: cover property (wdt_timeout_o);
	c_pin_a: cover property (irq_pin_a_o);
endmodule
bind acr_reg_bank acr_reg_bank_assertions CHK (
	.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .fifo_full_i(fifo_full_i),
	.fifo_watermark_i(fifo_watermark_i), .data_ready_i(data_ready_i),
	.slow_fault_i(slow_fault_i), .fatal_fault_i(fatal_fault_i),
	.irq_pin_a_o(irq_pin_a_o), .irq_pin_b_o(irq_pin_b_o), .cfg_o(cfg_o),
	.nvm_store_o(nvm_store_o), .wdt_timeout_o(wdt_timeout_o));
`default_nettype wire

// file: verification/acr_reg_bank_tb.sv
// Self-checking bench for the accelerometer register bank.
`timescale 1ns/1ps
`default_nettype none
module acr_reg_bank_tb;
	import acr_pkg::*;
	logic       sys_clk_i = 1'b0;
	logic       nrst_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       we = 1'b0;
	logic       re = 1'b0;
	logic [2:0] ev = 3'h0;
	logic       slow = 1'b0;
	logic       fatal = 1'b0;
	logic       loaded = 1'b0;
	logic       autocfg = 1'b0;
	logic       hold = 1'b0;
	logic       run = 1'b0;
	wire        scl;
	wire        sda;
	logic [7:0] rdata;
	logic       irq_a;
	logic       irq_b;
	acr_cfg_t   cfg;
	logic       store;
	logic       wdt;
	int         err_count = 0;
	int         total_checks = 0;
	logic [7:0] addrs [13] = '{8'h57, 8'h58, 8'h59, 8'h5e, 8'h5f, 8'h6a,
		8'h6b, 8'h6d, 8'h70, 8'h71, 8'h72, 8'h73, 8'h60};
	logic [7:0] masks [13] = '{8'hff, 8'h77, 8'hff, 8'hff, 8'h00, 8'h02,
		8'h11, 8'h0d, 8'h0f, 8'hff, 8'hff, 8'hff, 8'h00};
	logic [7:0] pat [2] = '{8'hff, 8'h5a};
	logic [7:0] s6b [3] = '{8'h11, 8'h00, 8'h01};
	logic [7:0] s6d [3] = '{8'h0d, 8'h00, 8'h04};
	logic [7:0] s70 [3] = '{8'h09, 8'h01, 8'h01};
	logic [7:0] sex [3] = '{8'hfd, 8'h02, 8'h94};
	logic [7:0] wcf [4] = '{8'h04, 8'h06, 8'h04, 8'h00};
	logic [1:0] wpn [4] = '{2'b01, 2'b01, 2'b10, 2'b01};
	int         wlo [4] = '{20, 50, 200, 200};
	int         whi [4] = '{26, 56, 200, 200};
	always #2 sys_clk_i = ~sys_clk_i;
	// Short watchdog limits keep the run brief.
	acr_reg_bank #(.WDT_SHORT_CYCLES(20), .WDT_LONG_CYCLES(50)) DUT (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(we), .reg_rd_i(re),
		.reg_rdata_o(rdata), .fifo_full_i(ev[0]), .fifo_watermark_i(ev[1]),
		.data_ready_i(ev[2]), .slow_fault_i(slow), .fatal_fault_i(fatal),
		.config_loaded_i(loaded), .autoconfig_mode_i(autocfg),
		.scl_i(scl), .sda_i(sda), .irq_pin_a_o(irq_a), .irq_pin_b_o(irq_b),
		.cfg_o(cfg), .nvm_store_o(store), .wdt_timeout_o(wdt));
	acr_i2c_host HOST (.hold_i(hold), .run_i(run), .scl_o(scl), .sda_o(sda));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk_i);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		re <= 1'b1;
		addr <= a;
		@(posedge sys_clk_i);
		re <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	// Counts cycles to a watchdog pulse; 200 means none came.
	task automatic wdt_wait(input int lo, input int hi);
		int n;
		n = 0;
		while (n < 200 && wdt !== 1'b1)
		begin
			@(posedge sys_clk_i);
			#1 n++;
		end
		chk({7'h0, n >= lo && n <= hi}, 8'h01);
	endtask
	task automatic close_out;
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		for (int i = 0; i < 13; i++)
			rd(addrs[i], addrs[i] == 8'h59 ? RST_INIT : RST_ZERO);
		foreach (pat[p])
			for (int i = 0; i < 13; i++)
			begin
				wr(addrs[i], pat[p]);
				rd(addrs[i], pat[p] & masks[i]);
			end
		chk(cfg.feat_cfg, 8'h5a);
		for (int p = 0; p < 2; p++)
			for (int e = 0; e < 3; e++)
			begin
				wr(ADDR_DATA_IRQ_ROUTING, 8'h01 << (4 * p + e));
				@(posedge sys_clk_i) ev <= 3'h1 << e;
				idle(2);
				chk({6'h0, irq_b, irq_a}, 8'h01 << p);
				@(posedge sys_clk_i) ev <= ~(3'h1 << e);
				idle(2);
				chk({6'h0, irq_b, irq_a}, 8'h00);
			end
		@(posedge sys_clk_i) ev <= 3'h0;
		wr(ADDR_COMMAND, CMD_SOFT_RESET);
		rd(ADDR_DATA_IRQ_ROUTING, RST_ZERO);
		rd(ADDR_INIT_COMMAND, RST_INIT);
		// Each init command goes out once after the soft reset.
		wr(ADDR_INIT_COMMAND, INIT_LOAD_CONFIG);
		idle(3);
		chk({6'h0, cfg.config_load_mode, cfg.features_enable}, 8'h02);
		@(posedge sys_clk_i) loaded <= 1'b1;
		wr(ADDR_INIT_COMMAND, INIT_START);
		idle(3);
		chk({6'h0, cfg.config_load_mode, cfg.features_enable}, 8'h01);
		@(posedge sys_clk_i) slow <= 1'b1;
		@(posedge sys_clk_i) slow <= 1'b0;
		rd(ADDR_INTERNAL_FAULT_FLAGS, 8'h02);
		chk({7'h0, cfg.processing_halt}, 8'h01);
		@(posedge sys_clk_i) fatal <= 1'b1;
		@(posedge sys_clk_i) fatal <= 1'b0;
		rd(ADDR_INTERNAL_FAULT_FLAGS, 8'h06);
		wr(ADDR_COMMAND, CMD_SOFT_RESET);
		rd(ADDR_INTERNAL_FAULT_FLAGS, RST_ZERO);
		for (int k = 0; k < 3; k++)
		begin
			wr(ADDR_SERIAL_PORT_CONFIG, s6b[k]);
			wr(ADDR_ACCEL_SELFTEST_CTRL, s6d[k]);
			wr(ADDR_NONVOLATILE_OPTIONS, s70[k]);
			@(posedge sys_clk_i) autocfg <= (k != 1);
			idle(3);
			chk({cfg.three_wire, cfg.aux_mag_mode, cfg.selftest_en,
				cfg.selftest_positive, cfg.selftest_high_amp, cfg.spi_select,
				cfg.i2c_enable, cfg.offset_add_en}, sex[k]);
		end
		@(posedge sys_clk_i) autocfg <= 1'b0;
		for (int k = 0; k < 4; k++)
		begin
			wr(ADDR_NONVOLATILE_OPTIONS, wcf[k]);
			@(posedge sys_clk_i) {run, hold} <= wpn[k];
			wdt_wait(wlo[k], whi[k]);
			@(posedge sys_clk_i) {run, hold} <= 2'b00;
			idle(60);
		end
		wr(ADDR_OFFSET_X, 8'h3c);
		wr(ADDR_COMMAND, CMD_NVM_STORE);
		#1 chk({7'h0, store}, 8'h00);
		wr(ADDR_COMMAND, CMD_SOFT_RESET);
		rd(ADDR_OFFSET_X, RST_ZERO);
		wr(ADDR_NVM_WRITE_CONTROL, 8'h02);
		wr(ADDR_OFFSET_X, 8'h3c);
		wr(ADDR_NONVOLATILE_OPTIONS, 8'h0f);
		wr(ADDR_COMMAND, CMD_NVM_STORE);
		#1 chk({7'h0, store}, 8'h01);
		chk({7'h0, cfg.nvm_write_allow}, 8'h01);
		wr(ADDR_COMMAND, CMD_SOFT_RESET);
		rd(ADDR_OFFSET_X, 8'h3c);
		rd(ADDR_NONVOLATILE_OPTIONS, 8'h0f);
		rd(ADDR_NVM_WRITE_CONTROL, RST_ZERO);
		chk(cfg.off_x, 8'h3c);
		close_out();
	end
endmodule
`default_nettype wire

// file: verilog/acr_pkg.sv
// Constants, register layout and carrier types of the accelerometer register bank.
`default_nettype none
package acr_pkg;

	// Register offsets.
	localparam logic [7:0] ADDR_PIN2_FEATURE_MAP     = 8'h57;
	localparam logic [7:0] ADDR_DATA_IRQ_ROUTING     = 8'h58;
	localparam logic [7:0] ADDR_INIT_COMMAND         = 8'h59;
	localparam logic [7:0] ADDR_FEATURE_CONFIG_PORT  = 8'h5e;
	localparam logic [7:0] ADDR_INTERNAL_FAULT_FLAGS = 8'h5f;
	localparam logic [7:0] ADDR_NVM_WRITE_CONTROL    = 8'h6a;
	localparam logic [7:0] ADDR_SERIAL_PORT_CONFIG   = 8'h6b;
	localparam logic [7:0] ADDR_ACCEL_SELFTEST_CTRL  = 8'h6d;
	localparam logic [7:0] ADDR_NONVOLATILE_OPTIONS  = 8'h70;
	localparam logic [7:0] ADDR_OFFSET_X             = 8'h71;
	localparam logic [7:0] ADDR_OFFSET_Y             = 8'h72;
	localparam logic [7:0] ADDR_OFFSET_Z             = 8'h73;
	localparam logic [7:0] ADDR_COMMAND              = 8'h7e;

	// Writable bit masks; every other bit is reserved and reads zero.
	localparam logic [7:0] MASK_FULL     = 8'hff;
	localparam logic [7:0] MASK_ROUTING  = 8'h77;
	localparam logic [7:0] MASK_NVM_CTL  = 8'h02;
	localparam logic [7:0] MASK_SERIAL   = 8'h11;
	localparam logic [7:0] MASK_SELFTEST = 8'h0d;
	localparam logic [7:0] MASK_NV_OPTS  = 8'h0f;

	// Reset values.
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_INIT = 8'h90;

	// Field positions.
	localparam int ROUTE_A_FULL  = 0;
	localparam int ROUTE_A_WM    = 1;
	localparam int ROUTE_A_DRDY  = 2;
	localparam int ROUTE_B_FULL  = 4;
	localparam int ROUTE_B_WM    = 5;
	localparam int ROUTE_B_DRDY  = 6;
	localparam int FAULT_SLOW    = 1;
	localparam int FAULT_FATAL   = 2;
	localparam int NVM_ALLOW     = 1;
	localparam int THREE_WIRE    = 0;
	localparam int AUX_MAG       = 4;
	localparam int ST_EN         = 0;
	localparam int ST_SIGN       = 2;
	localparam int ST_AMP        = 3;
	localparam int NV_SPI_EN     = 0;
	localparam int NV_WDT_LONG   = 1;
	localparam int NV_WDT_EN     = 2;
	localparam int NV_OFFSET_ADD = 3;

	// Command and init codes.
	localparam logic [7:0] INIT_LOAD_CONFIG = 8'h00;
	localparam logic [7:0] INIT_START       = 8'h01;
	localparam logic [7:0] CMD_NVM_STORE    = 8'ha0;
	localparam logic [7:0] CMD_SOFT_RESET   = 8'hb6;

	// Watchdog timing; the short timeout is given in tens of microseconds.
	localparam int CLK_PERIOD_PS   = 4000;
	localparam int WDT_SHORT_US100 = 125;
	localparam int WDT_LONG_MS     = 40;
	localparam int WDT_SHORT_CYC   = (WDT_SHORT_US100 * 10000000) / CLK_PERIOD_PS;
	localparam int WDT_LONG_CYC    = (WDT_LONG_MS * 1000000) / (CLK_PERIOD_PS / 1000);
	localparam int WDT_CNT_W       = 24;
	localparam int NVM_BYTES       = 4;

	typedef struct packed {
		logic [7:0] feat_map;
		logic [7:0] route;
		logic [7:0] init;
		logic [7:0] feat_cfg;
		logic [7:0] faults;
		logic [7:0] nvm_ctl;
		logic [7:0] serial;
		logic [7:0] selftest;
		logic [7:0] nv_opts;
		logic [7:0] off_x;
		logic [7:0] off_y;
		logic [7:0] off_z;
	} acr_regs_t;

	typedef struct packed {
		logic       three_wire;
		logic       aux_mag_mode;
		logic       selftest_en;
		logic       selftest_positive;
		logic       selftest_high_amp;
		logic       spi_select;
		logic       i2c_enable;
		logic       offset_add_en;
		logic       config_load_mode;
		logic       features_enable;
		logic       processing_halt;
		logic       nvm_write_allow;
		logic [7:0] feat_cfg;
		logic [7:0] feat_map;
		logic [7:0] off_x;
		logic [7:0] off_y;
		logic [7:0] off_z;
	} acr_cfg_t;

endpackage
`default_nettype wire

// file: verilog/acr_reg_bank.sv
// Configuration and status register bank with interrupt routing and bus watchdog.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module acr_reg_bank
	import acr_pkg::*;
#(
	parameter int WDT_SHORT_CYCLES = WDT_SHORT_CYC,
	parameter int WDT_LONG_CYCLES  = WDT_LONG_CYC
)
(
	// Clock and reset.
	input  wire logic       sys_clk_i,
	input  wire logic       nrst_i,
	// Register port.
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output var  logic [7:0] reg_rdata_o,
	// Internal events and status from the sensor core.
	input  wire logic       fifo_full_i,
	input  wire logic       fifo_watermark_i,
	input  wire logic       data_ready_i,
	input  wire logic       slow_fault_i,
	input  wire logic       fatal_fault_i,
	input  wire logic       config_loaded_i,
	input  wire logic       autoconfig_mode_i,
	// Serial bus pins, sampled for the watchdog.
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	// Interrupt pins.
	output var  logic       irq_pin_a_o,
	output var  logic       irq_pin_b_o,
	// Configuration to the rest of the device.
	output var  acr_cfg_t   cfg_o,
	output var  logic       nvm_store_o,
	output var  logic       wdt_timeout_o
);

	////////////////////////////////////////////////////////////////////////
	// Decoding helpers.

	// Writable bits of each address; zero marks an unmapped or read-only
	// location, so reserved bits can never be written.
	function automatic logic [7:0] write_mask(input logic [7:0] addr);
		logic [7:0] m;
		m = 8'h00;
		unique case (addr)
			ADDR_PIN2_FEATURE_MAP:    m = MASK_FULL;
			ADDR_DATA_IRQ_ROUTING:    m = MASK_ROUTING;
			ADDR_INIT_COMMAND:        m = MASK_FULL;
			ADDR_FEATURE_CONFIG_PORT: m = MASK_FULL;
			ADDR_NVM_WRITE_CONTROL:   m = MASK_NVM_CTL;
			ADDR_SERIAL_PORT_CONFIG:  m = MASK_SERIAL;
			ADDR_ACCEL_SELFTEST_CTRL: m = MASK_SELFTEST;
			ADDR_NONVOLATILE_OPTIONS: m = MASK_NV_OPTS;
			ADDR_OFFSET_X:            m = MASK_FULL;
			ADDR_OFFSET_Y:            m = MASK_FULL;
			ADDR_OFFSET_Z:            m = MASK_FULL;
			default:                  m = 8'h00;
		endcase
		return m;
	endfunction

	// Merge new data into an old value under the write mask of addr.
	function automatic logic [7:0] merge(input logic [7:0] old_v,
	                                     input logic [7:0] data,
	                                     input logic [7:0] addr);
		logic [7:0] m;
		m = write_mask(addr);
		return (old_v & ~m) | (data & m);
	endfunction

	// Read value; the command register and unmapped addresses read zero.
	function automatic logic [7:0] read_reg(input acr_regs_t r,
	                                        input logic [7:0] addr);
		logic [7:0] v;
		v = 8'h00;
		unique case (addr)
			ADDR_PIN2_FEATURE_MAP:     v = r.feat_map;
			ADDR_DATA_IRQ_ROUTING:     v = r.route & MASK_ROUTING;
			ADDR_INIT_COMMAND:         v = r.init;
			ADDR_FEATURE_CONFIG_PORT:  v = r.feat_cfg;
			ADDR_INTERNAL_FAULT_FLAGS: v = r.faults;
			ADDR_NVM_WRITE_CONTROL:    v = r.nvm_ctl & MASK_NVM_CTL;
			ADDR_SERIAL_PORT_CONFIG:   v = r.serial & MASK_SERIAL;
			ADDR_ACCEL_SELFTEST_CTRL:  v = r.selftest & MASK_SELFTEST;
			ADDR_NONVOLATILE_OPTIONS:  v = r.nv_opts & MASK_NV_OPTS;
			ADDR_OFFSET_X:             v = r.off_x;
			ADDR_OFFSET_Y:             v = r.off_y;
			ADDR_OFFSET_Z:             v = r.off_z;
			default:                   v = 8'h00;
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register file and NVM image.

	localparam acr_regs_t REGS_RESET = '{
		feat_map: RST_ZERO, route: RST_ZERO, init: RST_INIT,
		feat_cfg: RST_ZERO, faults: RST_ZERO, nvm_ctl: RST_ZERO,
		serial: RST_ZERO, selftest: RST_ZERO, nv_opts: RST_ZERO,
		off_x: RST_ZERO, off_y: RST_ZERO, off_z: RST_ZERO
	};

	acr_regs_t  regs_q;
	acr_regs_t  regs_d;
	logic [7:0] nvm_q [NVM_BYTES];
	logic [7:0] nvm_d [NVM_BYTES];
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       store_q;
	logic       store_d;
	logic       cmd_wr;

	assign cmd_wr = reg_wr_i && (reg_addr_i == ADDR_COMMAND);

	always_comb
	begin
		regs_d  = regs_q;
		nvm_d   = nvm_q;
		store_d = 1'b0;
		rdata_d = 8'h00;
		if (reg_rd_i)
		begin
			rdata_d = read_reg(regs_q, reg_addr_i);
		end
		if (cmd_wr && reg_wdata_i == CMD_SOFT_RESET)
		begin
			// Defaults everywhere, but the backed fields come back from NVM.
			regs_d         = REGS_RESET;
			regs_d.nv_opts = nvm_q[0] & MASK_NV_OPTS;
			regs_d.off_x   = nvm_q[1];
			regs_d.off_y   = nvm_q[2];
			regs_d.off_z   = nvm_q[3];
		end
		else
		begin
			if (reg_wr_i)
			begin
				unique case (reg_addr_i)
					ADDR_PIN2_FEATURE_MAP:
						regs_d.feat_map = merge(regs_q.feat_map, reg_wdata_i,
						                        reg_addr_i);
					ADDR_DATA_IRQ_ROUTING:
						regs_d.route = merge(regs_q.route, reg_wdata_i,
						                     reg_addr_i);
					ADDR_INIT_COMMAND:
						regs_d.init = reg_wdata_i;
					ADDR_FEATURE_CONFIG_PORT:
						regs_d.feat_cfg = reg_wdata_i;
					ADDR_NVM_WRITE_CONTROL:
						regs_d.nvm_ctl = merge(regs_q.nvm_ctl, reg_wdata_i,
						                       reg_addr_i);
					ADDR_SERIAL_PORT_CONFIG:
						regs_d.serial = merge(regs_q.serial, reg_wdata_i,
						                      reg_addr_i);
					ADDR_ACCEL_SELFTEST_CTRL:
						regs_d.selftest = merge(regs_q.selftest, reg_wdata_i,
						                        reg_addr_i);
					ADDR_NONVOLATILE_OPTIONS:
						regs_d.nv_opts = merge(regs_q.nv_opts, reg_wdata_i,
						                       reg_addr_i);
					ADDR_OFFSET_X:
						regs_d.off_x = reg_wdata_i;
					ADDR_OFFSET_Y:
						regs_d.off_y = reg_wdata_i;
					ADDR_OFFSET_Z:
						regs_d.off_z = reg_wdata_i;
					default:
						regs_d = regs_q;
				endcase
			end
			// Faults are sticky; only the soft reset command or power-on reset clears them.
			if (slow_fault_i)
			begin
				regs_d.faults[FAULT_SLOW] = 1'b1;
			end
			if (fatal_fault_i)
			begin
				regs_d.faults[FAULT_FATAL] = 1'b1;
			end
			// Without the allow bit the NVM stays read-only and the store
			// command is silently dropped.
			if (cmd_wr && reg_wdata_i == CMD_NVM_STORE &&
			    regs_q.nvm_ctl[NVM_ALLOW])
			begin
				nvm_d[0] = regs_q.nv_opts & MASK_NV_OPTS;
				nvm_d[1] = regs_q.off_x;
				nvm_d[2] = regs_q.off_y;
				nvm_d[3] = regs_q.off_z;
				store_d  = 1'b1;
			end
		end
	end

	// The image stands in for the array; it only clears on power-on reset.
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			regs_q  <= REGS_RESET;
			rdata_q <= 8'h00;
			store_q <= 1'b0;
			for (int i = 0; i < NVM_BYTES; i++)
			begin
				nvm_q[i] <= 8'h00;
			end
		end
		else
		begin
			regs_q  <= regs_d;
			rdata_q <= rdata_d;
			store_q <= store_d;
			nvm_q   <= nvm_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and SDA watchdog.

	logic [1:0]           scl_sync_q;
	logic [1:0]           sda_sync_q;
	logic                 scl_prev_q;
	logic [1:0]           scl_sync_d;
	logic [1:0]           sda_sync_d;
	logic                 scl_prev_d;
	logic [WDT_CNT_W-1:0] wdt_cnt_q;
	logic [WDT_CNT_W-1:0] wdt_cnt_d;
	logic [WDT_CNT_W-1:0] wdt_limit;
	logic                 wdt_fire_q;
	logic                 wdt_fire_d;
	logic                 wdt_active;

	// A stuck-low SDA with no SCL activity is what the watchdog frees.
	assign wdt_active = regs_q.nv_opts[NV_WDT_EN] &&
	                    !(autoconfig_mode_i && regs_q.nv_opts[NV_SPI_EN]);
	assign wdt_limit  = regs_q.nv_opts[NV_WDT_LONG] ?
	                    WDT_CNT_W'(WDT_LONG_CYCLES) :
	                    WDT_CNT_W'(WDT_SHORT_CYCLES);

	always_comb
	begin
		scl_sync_d = {scl_sync_q[0], scl_i};
		sda_sync_d = {sda_sync_q[0], sda_i};
		scl_prev_d = scl_sync_q[1];
		wdt_cnt_d  = wdt_cnt_q;
		wdt_fire_d = 1'b0;
		if (!wdt_active || sda_sync_q[1] || (scl_prev_q != scl_sync_q[1]))
		begin
			wdt_cnt_d = '0;
		end
		else if (wdt_cnt_q >= wdt_limit - 1'b1)
		begin
			wdt_cnt_d  = '0;
			wdt_fire_d = 1'b1;
		end
		else
		begin
			wdt_cnt_d = wdt_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_prev_q <= 1'b1;
			wdt_cnt_q  <= '0;
			wdt_fire_q <= 1'b0;
		end
		else
		begin
			scl_sync_q <= scl_sync_d;
			sda_sync_q <= sda_sync_d;
			scl_prev_q <= scl_prev_d;
			wdt_cnt_q  <= wdt_cnt_d;
			wdt_fire_q <= wdt_fire_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs.

	logic     irq_a_q;
	logic     irq_a_d;
	logic     irq_b_q;
	logic     irq_b_d;
	acr_cfg_t cfg_q;
	acr_cfg_t cfg_d;

	always_comb
	begin
		irq_a_d = (regs_q.route[ROUTE_A_FULL] && fifo_full_i) ||
		          (regs_q.route[ROUTE_A_WM]   && fifo_watermark_i) ||
		          (regs_q.route[ROUTE_A_DRDY] && data_ready_i);
		irq_b_d = (regs_q.route[ROUTE_B_FULL] && fifo_full_i) ||
		          (regs_q.route[ROUTE_B_WM]   && fifo_watermark_i) ||
		          (regs_q.route[ROUTE_B_DRDY] && data_ready_i);
		cfg_d.three_wire        = regs_q.serial[THREE_WIRE];
		cfg_d.aux_mag_mode      = regs_q.serial[AUX_MAG];
		cfg_d.selftest_en       = regs_q.selftest[ST_EN];
		cfg_d.selftest_positive = regs_q.selftest[ST_SIGN];
		cfg_d.selftest_high_amp = regs_q.selftest[ST_AMP];
		cfg_d.spi_select        = autoconfig_mode_i &&
		                          regs_q.nv_opts[NV_SPI_EN];
		cfg_d.i2c_enable        = !(autoconfig_mode_i &&
		                            regs_q.nv_opts[NV_SPI_EN]);
		cfg_d.offset_add_en     = regs_q.nv_opts[NV_OFFSET_ADD];
		cfg_d.config_load_mode  = regs_q.init == INIT_LOAD_CONFIG;
		cfg_d.features_enable   = (regs_q.init == INIT_START) &&
		                          config_loaded_i;
		cfg_d.processing_halt   = regs_q.faults[FAULT_SLOW] ||
		                          regs_q.faults[FAULT_FATAL];
		cfg_d.nvm_write_allow   = regs_q.nvm_ctl[NVM_ALLOW];
		cfg_d.feat_cfg          = regs_q.feat_cfg;
		cfg_d.feat_map          = regs_q.feat_map;
		cfg_d.off_x             = regs_q.off_x;
		cfg_d.off_y             = regs_q.off_y;
		cfg_d.off_z             = regs_q.off_z;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			irq_a_q <= 1'b0;
			irq_b_q <= 1'b0;
			cfg_q   <= '0;
		end
		else
		begin
			irq_a_q <= irq_a_d;
			irq_b_q <= irq_b_d;
			cfg_q   <= cfg_d;
		end
	end

	assign irq_pin_a_o   = irq_a_q;
	assign irq_pin_b_o   = irq_b_q;
	assign cfg_o         = cfg_q;
	assign reg_rdata_o   = rdata_q;
	assign nvm_store_o   = store_q;
	assign wdt_timeout_o = wdt_fire_q;

endmodule
`default_nettype wire
